//--- shared/irq_setup_pkg.sv
// constants and carriers for the bridge interrupt and filter setup block
// assumes a single 125 MHz clock domain
package irq_setup_pkg;
    // setup register
    localparam logic [3:0] SETUP_ADDR = 4'h8;
    localparam int SETUP_OVR_BIT = 1;
    localparam int SETUP_FEN_BIT = 0;
    localparam logic [7:0] SETUP_RESET = 8'h01;
    // mask control register (bit positions)
    localparam int MSK_DISC_BIT = 7;
    localparam int MSK_CHG_BIT = 6;
    localparam int MSK_BIN_BIT = 5;
    localparam int MSK_BOUT_BIT = 4;
    localparam int MSK_FLT_BIT = 3;
    localparam logic [7:0] MASK_RESET = 8'hFB;
    localparam logic [7:0] STATUS_RESET = 8'h03;
    // status bit positions: pending flags and live empty flags
    localparam int ST_ACK_BIT = 4;
    localparam int ST_FLT_BIT = 3;
    localparam int ST_BIN_BIT = 2;
    localparam int ST_BIN_EMPTY_BIT = 1;
    localparam int ST_BOUT_EMPTY_BIT = 0;
    localparam logic [2:0] MODE_ECP = 3'h3;
    // timing
    localparam longint CLK_HZ = 125000000;
    localparam int DISC_TIME_MS = 1000;
    localparam longint DISC_CYCLES = CLK_HZ * DISC_TIME_MS / 1000;
    localparam int EPP_TIMEOUT_US = 10;
    localparam int EPP_CYCLES = EPP_TIMEOUT_US * 125;
    localparam int FILT_LEN = 3;

    typedef struct packed {
        logic plh;
        logic select;
        logic perror;
        logic nfault;
        logic busy;
        logic nack;
    } periph_lines_t;

    typedef struct packed {
        logic ack;
        logic epp_to;
        logic fault;
        logic bulk_in;
        logic bulk_out;
        logic change;
        logic disconnect;
    } irq_src_t;
endpackage

//--- core/line_filter.sv
// per-line synchroniser with optional all-samples-agree digital filter
// assumes raw lines may be asynchronous to the clock
`timescale 1ns/1ps
module line_filter import irq_setup_pkg::*; (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // lines
    input wire periph_lines_t i_raw,
    input wire logic i_filter_en,
    output periph_lines_t o_clean
);
    periph_lines_t sync1_reg;
    periph_lines_t sync2_reg;
    periph_lines_t hist_reg [FILT_LEN];
    periph_lines_t all_one;
    periph_lines_t all_zero;
    periph_lines_t filt_reg;

    always_comb begin
        all_one = '1;
        all_zero = '1;
        for (int k = 0; k < FILT_LEN; k++) begin
            all_one = all_one & hist_reg[k];
            all_zero = all_zero & ~hist_reg[k];
        end
    end

    // two flops before anything looks at the lines
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            filt_reg <= '1;
            for (int k = 0; k < FILT_LEN; k++) hist_reg[k] <= '1;
        end else if (i_ce) begin
            sync1_reg <= i_raw;
            sync2_reg <= sync1_reg;
            hist_reg[0] <= sync2_reg;
            for (int k = 1; k < FILT_LEN; k++) hist_reg[k] <= hist_reg[k-1];
            // a line moves only after it held steady for the full window
            filt_reg <= (filt_reg | all_one) & ~all_zero;
        end
    end

    // bypass trades noise immunity for latency
    assign o_clean = i_filter_en ? filt_reg : sync2_reg;
endmodule // line_filter

//--- core/irq_setup.sv
// interrupt condition tracking and input filter setup for the bridge
// assumes register port is synchronous, reads are single-cycle strobes
`timescale 1ns/1ps
module irq_setup import irq_setup_pkg::*; #(
    parameter longint DISC_LIMIT = DISC_CYCLES
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // control inputs from other registers
    input wire logic [7:0] i_mask_ctl,
    input wire logic i_int_enable,
    input wire logic i_epp_to_mask,
    input wire logic [2:0] i_mode,
    // transfer engine status
    input wire logic i_epp_busy,
    input wire logic i_epp_ack,
    input wire logic i_bulk_in_avail,
    input wire logic i_bulk_out_pending,
    // parallel side
    input wire periph_lines_t i_lines,
    input wire logic i_filter_strap,
    // outputs
    output logic o_filter_active,
    output logic [7:0] o_status,
    output logic o_irq_pending,
    output logic o_epp_timeout
);
    logic [7:0] setup_reg;
    periph_lines_t clean;
    periph_lines_t prev_reg;
    irq_src_t pend_reg;
    irq_src_t evt;
    logic [7:0] status_next;
    logic [10:0] epp_cnt_reg;
    logic [27:0] disc_cnt_reg;
    logic filt_sel;
    logic rd_clear;
    logic epp_hit;
    logic disc_idle;
    logic disc_hit;
    logic bout_prev_reg;
    logic fault_en_prev_reg;
    logic bin_st;
    logic bout_empty;
    logic fault_armed;
    irq_src_t pend_kept;

    // filter source select
    assign filt_sel = setup_reg[SETUP_OVR_BIT] ? setup_reg[SETUP_FEN_BIT] : i_filter_strap;

    line_filter u_filter (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_raw(i_lines),
        .i_filter_en(filt_sel),
        .o_clean(clean)
    );

    // any read of the block clears pending
    assign rd_clear = i_rd;
    assign bin_st = i_bulk_in_avail;
    // fault source live only in ECP with its mask open
    assign fault_armed = (i_mode == MODE_ECP) && !i_mask_ctl[MSK_FLT_BIT];
    // clear applied first so a same-cycle event still lands
    assign pend_kept = rd_clear ? '0 : pend_reg;
    assign bout_empty = !i_bulk_out_pending;
    assign epp_hit = i_epp_busy && !i_epp_ack && (epp_cnt_reg == 11'(EPP_CYCLES - 1));
    assign disc_idle = !clean.plh && clean.nack && clean.busy && clean.nfault
        && clean.perror && clean.select;
    assign disc_hit = (prev_reg.plh && !clean.plh)
        || (disc_idle && disc_cnt_reg == 28'(DISC_LIMIT));

    always_comb begin
        evt.ack = i_int_enable && !prev_reg.nack && clean.nack;
        evt.epp_to = !i_epp_to_mask && epp_hit;
        evt.fault = fault_armed
            && ((prev_reg.nfault && !clean.nfault)
            || (!clean.nfault && fault_en_prev_reg == 1'b0));
        evt.bulk_in = !i_mask_ctl[MSK_BIN_BIT] && bin_st;
        evt.bulk_out = !i_mask_ctl[MSK_BOUT_BIT] && bout_empty && !bout_prev_reg;
        evt.change = !i_mask_ctl[MSK_CHG_BIT] && (clean != prev_reg);
        evt.disconnect = !i_mask_ctl[MSK_DISC_BIT] && disc_hit;
    end

    // change and disconnect carry no status bit of their own
    always_comb begin
        status_next = 8'h00;
        status_next[ST_ACK_BIT] = pend_reg.ack;
        status_next[ST_FLT_BIT] = pend_reg.fault;
        status_next[ST_BIN_BIT] = pend_reg.bulk_in;
        status_next[ST_BIN_EMPTY_BIT] = !bin_st;
        status_next[ST_BOUT_EMPTY_BIT] = bout_empty;
    end

    // setup register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            setup_reg <= SETUP_RESET;
        end else if (i_ce && i_wr && i_addr == SETUP_ADDR) begin
            setup_reg <= i_wdata;
        end
    end

    // sticky pending, a new event wins over the read clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_reg <= '0;
        end else if (i_ce) begin
            pend_reg <= pend_kept | evt;
        end
    end

    // history for edge and level-unmask detection
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_reg <= '1;
            bout_prev_reg <= 1'b1;
            fault_en_prev_reg <= 1'b0;
        end else if (i_ce) begin
            prev_reg <= clean;
            bout_prev_reg <= bout_empty;
            // level fault fires once per unmask, not every cycle
            fault_en_prev_reg <= fault_armed && !clean.nfault;
        end
    end

    // handshake and idle timers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            epp_cnt_reg <= '0;
            disc_cnt_reg <= '0;
        end else if (i_ce) begin
            epp_cnt_reg <= (i_epp_busy && !i_epp_ack && !epp_hit) ? epp_cnt_reg + 11'd1 : '0;
            // saturates past the limit so the idle hit fires once
            if (!disc_idle) disc_cnt_reg <= '0;
            else if (disc_cnt_reg <= 28'(DISC_LIMIT)) disc_cnt_reg <= disc_cnt_reg + 28'd1;
        end
    end

    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
            o_filter_active <= 1'b1;
            o_status <= STATUS_RESET;
            o_irq_pending <= 1'b0;
            o_epp_timeout <= 1'b0;
        end else if (i_ce) begin
            o_rdata <= (i_addr == SETUP_ADDR) ? setup_reg : status_next;
            o_filter_active <= filt_sel;
            o_status <= status_next;
            o_irq_pending <= |(pend_kept | evt);
            o_epp_timeout <= epp_hit;
        end
    end

    chk_read_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_ce && i_rd && evt == '0) |=> pend_reg == '0) else $error("read did not clear");
    chk_filter_select: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_ce && setup_reg[SETUP_OVR_BIT]) |=> o_filter_active == $past(setup_reg[SETUP_FEN_BIT]))
        else $error("filter select wrong");
    chk_ack_edge: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_ce && i_int_enable && !prev_reg.nack && clean.nack) |=> pend_reg.ack)
        else $error("ack edge lost");
    chk_bout_empty: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_ce |=> o_status[ST_BOUT_EMPTY_BIT] == !$past(i_bulk_out_pending))
        else $error("bulk out empty wrong");

    // multi-step behaviours as named sequences
    sequence s_plh_fall;
        (i_ce && clean.plh) ##1 (i_ce && !clean.plh && !i_mask_ctl[MSK_DISC_BIT]);
    endsequence
    sequence s_line_moved;
        i_ce && !i_mask_ctl[MSK_CHG_BIT] && (clean != prev_reg);
    endsequence
    // level fault counts once, on the cycle it becomes true
    sequence s_fault_unmask;
        (i_ce && !(fault_armed && !clean.nfault)) ##1 (i_ce && fault_armed && !clean.nfault);
    endsequence
    chk_disc_fall: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        s_plh_fall |=> pend_reg.disconnect) else $error("disconnect edge lost");
    chk_change_irq: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        s_line_moved |=> o_irq_pending) else $error("line change missed");
    chk_fault_level: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        s_fault_unmask |=> pend_reg.fault) else $error("fault level lost");
    chk_epp_report: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_ce && epp_hit && !i_epp_to_mask) |=> (o_epp_timeout && pend_reg.epp_to))
        else $error("time-out not reported");
    chk_bin_empty: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_ce |=> o_status[ST_BIN_EMPTY_BIT] == !$past(i_bulk_in_avail))
        else $error("bulk in empty wrong");
    chk_setup_read: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_ce && i_addr == SETUP_ADDR) |=> o_rdata == $past(setup_reg))
        else $error("setup readback wrong");
endmodule // irq_setup

//--- tb/host_poll.sv
// host model: byte register reads and writes on the block's port
// assumes one clock, requests launched just after rising edges
`timescale 1ns/1ps
module host_poll (
    // clock
    input wire logic i_ref_clk,
    // register port
    output logic [3:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial begin
        o_addr = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // one-cycle strobe; read data taken just after the strobe edge
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wr <= w;
        o_rd <= !w;
        o_wdata <= d;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        #1 q = i_rdata;
    endtask
endmodule // host_poll

//--- tb/irq_setup_tb.sv
// self-checking bench for the interrupt and filter setup block
// assumes host_poll owns the register port, bench owns the rest
`timescale 1ns/1ps
module irq_setup_tb import irq_setup_pkg::*;;
    logic clk, nrst, strap, int_en, to_mask, ebusy, eack, bin, bout, wr, rd;
    logic fact, irq, eto, ce;
    logic [7:0] mask, rdata, status, wdata, q;
    logic [3:0] addr;
    logic [2:0] mode;
    periph_lines_t lines;
    int err_count, total_checks;
    host_poll host_u (.i_ref_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .i_rdata(rdata));
    // short disconnect limit keeps the run brief
    irq_setup #(.DISC_LIMIT(20)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce),
        .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
        .i_mask_ctl(mask), .i_int_enable(int_en), .i_epp_to_mask(to_mask),
        .i_mode(mode), .i_epp_busy(ebusy), .i_epp_ack(eack),
        .i_bulk_in_avail(bin), .i_bulk_out_pending(bout), .i_lines(lines),
        .i_filter_strap(strap), .o_filter_active(fact), .o_status(status),
        .o_irq_pending(irq), .o_epp_timeout(eto));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 30 && irq !== 1'b1; i++) step(1);
        // status is built from pending, so it trails the irq by a cycle
        step(1);
    endtask
    task automatic wr_setup(input logic [7:0] d);
        host_u.access(1'b1, SETUP_ADDR, d, q);
        step(3);
    endtask
    task automatic clear();
        host_u.access(1'b0, 4'h0, 8'h00, q);
        step(2);
    endtask
    task automatic t_reset();
        chk("status", 8'h03, status);
        chk("filter", 8'h01, {7'h00, fact});
        host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
        chk("setup", SETUP_RESET, q);
    endtask
    task automatic t_freeze();
        ce <= 1'b0;
        host_u.access(1'b1, SETUP_ADDR, 8'h03, q);
        step(2);
        chk("frozen", 8'h00, {7'h00, fact});
        ce <= 1'b1;
        host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
        chk("setup", 8'h02, q);
    endtask
    task automatic t_rst2();
        lines <= 6'h3F;
        nrst <= 1'b0;
        step(2);
        chk("irq_rst", 8'h00, {7'h00, irq});
        nrst <= 1'b1;
        step(1);
        chk("status", 8'h03, status);
        chk("filter", 8'h00, {7'h00, fact});
        host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
        chk("setup", SETUP_RESET, q);
    endtask
    task automatic t_filter();
        wr_setup(8'h02);
        chk("filter", 8'h00, {7'h00, fact});
        wr_setup(8'h03);
        chk("filter", 8'h01, {7'h00, fact});
        wr_setup(8'h00);
        strap <= 1'b0;
        step(4);
        chk("filter", 8'h00, {7'h00, fact});
        wr_setup(8'h02);
        host_u.access(1'b1, 4'h4, 8'h01, q);
        host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
        chk("setup", 8'h02, q);
    endtask
    task automatic t_ack();
        int_en <= 1'b1;
        lines.nack <= 1'b0;
        step(8);
        clear();
        lines.nack <= 1'b1;
        wait_irq();
        chk("ack", 8'h11, {3'h0, status[ST_ACK_BIT], 3'h0, irq});
        host_u.access(1'b0, 4'h0, 8'h00, q);
        chk("rd_status", 8'h13, q);
        step(2);
        chk("ack", 8'h00, {3'h0, status[ST_ACK_BIT], 3'h0, irq});
    endtask
    task automatic t_fault();
        mask <= 8'hF3;
        mode <= 3'h1;
        lines.nfault <= 1'b0;
        step(8);
        chk("fault", 8'h00, {7'h00, status[ST_FLT_BIT]});
        mode <= MODE_ECP;
        wait_irq();
        chk("fault", 8'h01, {7'h00, status[ST_FLT_BIT]});
        lines.nfault <= 1'b1;
        mask <= 8'hFB;
        step(8);
        clear();
    endtask
    task automatic t_bulk();
        mask <= 8'hDB;
        bin <= 1'b1;
        wait_irq();
        chk("bin", 8'h05, {5'h00, status[2:0]});
        bin <= 1'b0;
        mask <= 8'hEB;
        bout <= 1'b1;
        step(4);
        clear();
        chk("bout", 8'h02, {5'h00, status[2:0]});
        bout <= 1'b0;
        wait_irq();
        chk("bout", 8'h03, {6'h00, status[ST_BOUT_EMPTY_BIT], irq});
        clear();
    endtask
    task automatic t_epp();
        int i;
        logic seen;
        seen = 1'b0;
        int_en <= 1'b0;
        to_mask <= 1'b0;
        ebusy <= 1'b1;
        eack <= 1'b1;
        for (i = 0; i < EPP_CYCLES + 20; i++) begin
            step(1);
            seen = seen | eto;
        end
        chk("answered", 8'h00, {7'h00, seen});
        eack <= 1'b0;
        for (i = 0; i < EPP_CYCLES + 50 && eto !== 1'b1; i++) step(1);
        chk("timeout", 8'h01, {7'h00, eto});
        step(3);
        chk("to_irq", 8'h01, {7'h00, irq});
        ebusy <= 1'b0;
        clear();
    endtask
    task automatic t_line();
        mask <= 8'hBB;
        lines.busy <= 1'b0;
        wait_irq();
        chk("change", 8'h01, {7'h00, irq});
        lines.busy <= 1'b1;
        step(8);
        mask <= 8'h7B;
        clear();
        lines.plh <= 1'b0;
        wait_irq();
        chk("disc", 8'h01, {status[4:2], 4'h0, irq});
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // free-running clock stands in for the external low clock input
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100us;
        err_count++;
        conclude();
    end
    initial begin
        {nrst, int_en, ebusy, eack, bin, bout} = 6'h00;
        ce = 1'b1;
        {strap, to_mask, mode, mask, lines} = {2'b11, 3'h0, 8'hFB, 6'h3F};
        err_count = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        step(1);
        t_reset();
        t_filter();
        t_freeze();
        t_ack();
        t_fault();
        t_bulk();
        t_epp();
        t_line();
        t_rst2();
        conclude();
    end
endmodule // irq_setup_tb
